// ===== rtl/csr_cfg.svh
/*
 * Offsets, field positions, reset values and the transfer map of the color
 * setpoint register block. Assumes inclusion by bare name, once or more.
 */
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

// ==========================================================================
// Register offsets
`define CSR_OFF_CTRL2 8'h02
`define CSR_OFF_CONFIG2 8'h04
`define CSR_OFF_ERROR 8'h23
`define CSR_OFF_SENSOR_ACQ_CONSTANT 8'hA9

// ==========================================================================
// Field positions
`define CSR_BIT_SAVE_CALIB_CMD 4
`define CSR_BIT_OPMD 0
`define CSR_BIT_NACK 5
`define CSR_MASK_POLARITY 8'h02
`define CSR_MASK_BRT_HI 8'h0F
`define CSR_MASK_TWO_BIT 8'h03
`define CSR_MASK_FULL 8'hFF
`define CSR_MASK_CONFIG 8'h07

// ==========================================================================
// Transfer locations
`define CSR_LOC_FIRST 7'h01
`define CSR_LOC_LAST 7'h47
`define CSR_LOC_CONFIG 7'h02
`define CSR_LOC_CAL_A_END 7'h0F
`define CSR_LOC_CAL_B_START 7'h23
`define CSR_LOC_CP_FIRST 7'h17
`define CSR_LOC_CP_LAST 7'h1E
`define CSR_LOC_BRT_LO 7'h17
`define CSR_LOC_BRT_HI 7'h18
`define CSR_LOC_Y_HI 7'h1A
`define CSR_LOC_X_HI 7'h1C
`define CSR_LOC_L_HI 7'h1E
`define CSR_LOC_SAMP_LO 7'h04
`define CSR_LOC_SAMP_HI 7'h05

// ==========================================================================
// Reset values and limits
`define CSR_RST_BRT_LO 8'h79
`define CSR_RST_BRT_HI 8'h0E
`define CSR_RST_SAMP_LO 8'h30
`define CSR_RST_SAMP_HI 8'h75
`define CSR_BRT_MAX 24'h000E79

// Register address per location, first entry is location 01
`define CSR_LOC_MAP {8'h00, 8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, \
    8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, \
    8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'hE8, 8'hE9, 8'hEA, 8'hEB, \
    8'hEC, 8'hED, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'h81, 8'h82, 8'h83, 8'h8A, \
    8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, \
    8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'h9E, \
    8'h9F, 8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, \
    8'h1B, 8'h1F, 8'h20}

`endif

// ===== rtl/csr_eemap.sv
/*
 * Address decoder: finds the transfer location that holds a register
 * address. Purely combinational; assumes the caller registers the result.
 */
`timescale 1ns/1ps
`include "csr_cfg.svh"

module csr_eemap (
    // Register address in
    input wire logic [7:0] reg_addr,
    // Location out
    output logic hit,
    output logic [6:0] loc
);
    import csr_pkg::*;

    localparam logic [70:0][7:0] LOC_MAP = `CSR_LOC_MAP;

    logic [71:0] match;

    // Location 00 holds nothing
    assign match[0] = 1'b0;

    // One comparator per location
    genvar g;
    generate
        for (g = 1; g < 72; g++)
        begin : g_cmp
            assign match[g] = (reg_addr == LOC_MAP[71 - g]);
        end
    endgenerate

    // Encode the matching location
    always_comb
    begin
        hit = |match;
        loc = 7'h00;
        for (int i = 1; i < 72; i++)
        begin
            if (match[i])
                loc = 7'(i);
        end
    end

endmodule

// ===== rtl/csr_pkg.sv
/*
 * Types of the color setpoint register block: sequencer states, transfer
 * operations, the EEPROM request carrier and the block state record.
 * Assumes nothing of its surroundings.
 */
package csr_pkg;

    // ======================================================================
    // Sequencer states and operations
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_XFER = 3'b010,
        ST_FINISH = 3'b100
    } csr_seq_e;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_SAVE_ALL = 3'h1,
        OP_RESTORE_ALL = 3'h2,
        OP_SAVE_CAL = 3'h3,
        OP_RESTORE_CAL = 3'h4,
        OP_SAVE_CP = 3'h5
    } csr_op_e;

    // ======================================================================
    // EEPROM byte request
    typedef struct packed {
        logic req;
        logic wr;
        logic [7:0] loc;
        logic [7:0] wdata;
    } csr_ee_req_s;

    // ======================================================================
    // Whole block state
    typedef struct packed {
        logic [71:0][7:0] mem;
        logic [7:0] sensor_acq_constant;
        logic save_calib_cmd;
        logic upl_from_bit;
        logic opmd;
        logic nack;
        csr_seq_e seq;
        csr_op_e op;
        logic [6:0] loc;
        csr_ee_req_s ee;
        logic [7:0] rdata;
        logic [11:0] duty;
    } csr_state_s;

endpackage

// ===== rtl/csr_top.sv
/*
 * Color setpoint register block with its EEPROM transfer sequencer and the
 * brightness duty limiter.
 * Assumes the serial host decoder, the EEPROM master and the duty source
 * run on REF_CLK, so their signals need no synchroniser.
 */
// What this block and its software do
// [R1] Software sets acquisition constant from sampling and PWM settings, rounded down.
// [R2] Software writes nine when the computed acquisition constant exceeds nine.
// [R3] Software retunes rates when the acquisition constant comes out negative.
// [R4] Stabilized duty stays below the programmed 12-bit brightness limit; the code holds duty at zero when the limit is zero.
// [R5] Software never writes a brightness limit above 3705.
// [R6] Brightness scales with limit divided by 3705.
// [R7] Chromaticity y holds y times 1000, low byte plus two-bit high.
// [R8] Chromaticity x holds x times 1000, low byte plus two-bit high.
// [R9] Software programs luminance reference to 1000.
// [R10] Reserved bits of brightness, chromaticity and luminance high bytes read zero.
// [R11] Full save or restore moves locations 01 to 47 in map order.
// [R12] Calibration save or restore moves locations 02-0F and 23-47 only.
// [R13] Configuration transfer keeps only PWM polarity, other bits zero.
// [R14] Color-point save writes locations 17 to 1E only.
// [R15] Calibration upload bit saves calibration data, clears when done, open loop only.
// [R16] Locations go in ascending order; unacknowledged bytes leave registers unchanged.
`timescale 1ns/1ps
`include "csr_cfg.svh"

module csr_top (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // Register access port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Transfer commands, one-cycle pulses
    input wire logic SAVE_ALL_CMD,
    input wire logic RESTORE_ALL_CMD,
    input wire logic SAVE_CALIB_CMD,
    input wire logic RESTORE_CALIB_CMD,
    input wire logic SAVE_COLOR_POINT_CMD,
    // EEPROM byte port
    output csr_pkg::csr_ee_req_s EE_REQ,
    input wire logic EE_DONE,
    input wire logic EE_ACK,
    input wire logic [7:0] EE_RDATA,
    // Duty path
    input wire logic [11:0] DUTY_REQ,
    output logic [11:0] DUTY_OUT
);
    import csr_pkg::*;

    csr_state_s s_ff;
    csr_state_s nxt_s;
    logic map_hit;
    logic [6:0] map_loc;
    logic [11:0] limit;
    logic [23:0] prod;
    logic [23:0] scaled;

    // ======================================================================
    // Address decode
    csr_eemap u_map (
        .reg_addr(REG_ADDR),
        .hit(map_hit),
        .loc(map_loc)
    );

    // ======================================================================
    // Helpers

    // Bits that exist at each location; at configuration only the polarity bit that transfers
    function automatic logic [7:0] mask_of(input logic [6:0] l);
        if (l == `CSR_LOC_CONFIG)
            mask_of = `CSR_MASK_POLARITY; // see [R13]
        else if (l == `CSR_LOC_BRT_HI)
            mask_of = `CSR_MASK_BRT_HI; // see [R10]
        else if (l == `CSR_LOC_Y_HI || l == `CSR_LOC_X_HI || l == `CSR_LOC_L_HI)
            mask_of = `CSR_MASK_TWO_BIT; // see [R7] see [R8] see [R10]
        else
            mask_of = `CSR_MASK_FULL;
    endfunction

    // Following location of an operation
    function automatic logic [6:0] next_loc(input csr_op_e o, input logic [6:0] l);
        if ((o == OP_SAVE_CAL || o == OP_RESTORE_CAL) && l == `CSR_LOC_CAL_A_END)
            next_loc = `CSR_LOC_CAL_B_START; // see [R12]
        else
            next_loc = l + 7'h01; // see [R16]
    endfunction

    // Last location of an operation
    function automatic logic [6:0] last_loc(input csr_op_e o);
        if (o == OP_SAVE_CP)
            last_loc = `CSR_LOC_CP_LAST; // see [R14]
        else
            last_loc = `CSR_LOC_LAST; // see [R11]
    endfunction

    // ======================================================================
    // Duty limiter
    assign limit = {s_ff.mem[`CSR_LOC_BRT_HI][3:0], s_ff.mem[`CSR_LOC_BRT_LO]};
    assign prod = DUTY_REQ * limit;
    assign scaled = prod / `CSR_BRT_MAX; // see [R6]

    // ======================================================================
    // Next state
    always_comb
    begin
        nxt_s = s_ff;
        // Sequencer
        case (s_ff.seq)
            ST_IDLE:
            begin
                nxt_s.op = OP_NONE;
                nxt_s.upl_from_bit = 1'b0;
                if (SAVE_ALL_CMD)
                    nxt_s.op = OP_SAVE_ALL;
                else if (RESTORE_ALL_CMD)
                    nxt_s.op = OP_RESTORE_ALL;
                else if (SAVE_CALIB_CMD)
                    nxt_s.op = OP_SAVE_CAL;
                else if (RESTORE_CALIB_CMD)
                    nxt_s.op = OP_RESTORE_CAL;
                else if (SAVE_COLOR_POINT_CMD)
                    nxt_s.op = OP_SAVE_CP;
                else if (s_ff.save_calib_cmd)
                begin
                    nxt_s.op = OP_SAVE_CAL; // see [R15]
                    nxt_s.upl_from_bit = 1'b1;
                end
                if (nxt_s.op != OP_NONE)
                begin
                    nxt_s.nack = 1'b0;
                    if (nxt_s.op == OP_SAVE_CP)
                        nxt_s.loc = `CSR_LOC_CP_FIRST; // see [R14]
                    else if (nxt_s.op == OP_SAVE_CAL || nxt_s.op == OP_RESTORE_CAL)
                        nxt_s.loc = `CSR_LOC_CONFIG; // see [R12]
                    else
                        nxt_s.loc = `CSR_LOC_FIRST; // see [R11]
                    nxt_s.seq = ST_XFER;
                end
            end
            ST_XFER:
            begin
                if (EE_DONE)
                begin
                    if (!s_ff.ee.wr && EE_ACK)
                        nxt_s.mem[s_ff.loc] = EE_RDATA & mask_of(s_ff.loc); // see [R13]
                    if (!EE_ACK)
                        nxt_s.nack = 1'b1; // see [R16]
                    if (s_ff.loc == last_loc(s_ff.op))
                        nxt_s.seq = ST_FINISH;
                    else
                        nxt_s.loc = next_loc(s_ff.op, s_ff.loc);
                end
            end
            ST_FINISH:
            begin
                if (s_ff.upl_from_bit)
                    nxt_s.save_calib_cmd = 1'b0; // see [R15]
                nxt_s.seq = ST_IDLE;
            end
            default:
            begin
                nxt_s.seq = ST_IDLE;
            end
        endcase
        // EEPROM request follows the location
        nxt_s.ee.req = (nxt_s.seq == ST_XFER);
        nxt_s.ee.wr = (nxt_s.op == OP_SAVE_ALL || nxt_s.op == OP_SAVE_CAL ||
            nxt_s.op == OP_SAVE_CP);
        nxt_s.ee.loc = {1'b0, nxt_s.loc};
        nxt_s.ee.wdata = s_ff.mem[nxt_s.loc] & mask_of(nxt_s.loc); // see [R13]
        // Register writes, after the sequencer so a set wins over a clear
        if (REG_WR)
        begin
            if (map_hit && map_loc == `CSR_LOC_CONFIG)
                nxt_s.mem[map_loc] = REG_WDATA & `CSR_MASK_CONFIG; // All live bits kept
            else if (map_hit)
                nxt_s.mem[map_loc] = REG_WDATA & mask_of(map_loc); // see [R10]
            else if (REG_ADDR == `CSR_OFF_CTRL2)
            begin
                if (REG_WDATA[`CSR_BIT_SAVE_CALIB_CMD] && s_ff.opmd)
                    nxt_s.save_calib_cmd = 1'b1; // see [R15]
            end
            else if (REG_ADDR == `CSR_OFF_CONFIG2)
                nxt_s.opmd = REG_WDATA[`CSR_BIT_OPMD];
            else if (REG_ADDR == `CSR_OFF_SENSOR_ACQ_CONSTANT)
                nxt_s.sensor_acq_constant = REG_WDATA;
        end
        // Read data
        nxt_s.rdata = 8'h00;
        if (map_hit)
            nxt_s.rdata = s_ff.mem[map_loc];
        else if (REG_ADDR == `CSR_OFF_CTRL2)
            nxt_s.rdata[`CSR_BIT_SAVE_CALIB_CMD] = s_ff.save_calib_cmd;
        else if (REG_ADDR == `CSR_OFF_CONFIG2)
            nxt_s.rdata[`CSR_BIT_OPMD] = s_ff.opmd;
        else if (REG_ADDR == `CSR_OFF_ERROR)
            nxt_s.rdata[`CSR_BIT_NACK] = s_ff.nack;
        else if (REG_ADDR == `CSR_OFF_SENSOR_ACQ_CONSTANT)
            nxt_s.rdata = s_ff.sensor_acq_constant;
        // Duty kept strictly below a nonzero limit, and zero when the limit is zero
        if (limit == 12'h000)
            nxt_s.duty = 12'h000; // see [R4]
        else if (scaled >= {12'h000, limit})
            nxt_s.duty = limit - 12'h001; // see [R4]
        else
            nxt_s.duty = scaled[11:0]; // see [R6]
    end

    // ======================================================================
    // State register
    always_ff @(posedge REF_CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s_ff <= '0;
            s_ff.seq <= ST_IDLE;
            s_ff.mem[`CSR_LOC_BRT_LO] <= `CSR_RST_BRT_LO;
            s_ff.mem[`CSR_LOC_BRT_HI] <= `CSR_RST_BRT_HI;
            s_ff.mem[`CSR_LOC_SAMP_LO] <= `CSR_RST_SAMP_LO;
            s_ff.mem[`CSR_LOC_SAMP_HI] <= `CSR_RST_SAMP_HI;
        end
        else
            s_ff <= nxt_s;
    end

    // Outputs straight from the state register
    assign REG_RDATA = s_ff.rdata;
    assign EE_REQ = s_ff.ee;
    assign DUTY_OUT = s_ff.duty;

    // ======================================================================
    // Checks
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_byte_done;
        s_ff.seq == ST_XFER && EE_DONE && s_ff.loc != last_loc(s_ff.op);
    endsequence

    sequence s_cal_gap;
        s_byte_done ##0 (s_ff.op == OP_SAVE_CAL || s_ff.op == OP_RESTORE_CAL) &&
            s_ff.loc == `CSR_LOC_CAL_A_END;
    endsequence

    a_duty_below_limit: assert property (limit != 12'h000 |=> DUTY_OUT < $past(limit))
        else $error("duty not below brightness limit"); // see [R4]
    a_seq_ascend: assert property (s_byte_done |=> EE_REQ.req && EE_REQ.loc > $past(EE_REQ.loc))
        else $error("transfer location did not ascend"); // see [R16]
    a_cal_skip: assert property (s_cal_gap |=> EE_REQ.loc == 8'h23)
        else $error("calibration transfer did not skip to 23"); // see [R12]
    a_cp_window: assert property (EE_REQ.req && s_ff.op == OP_SAVE_CP |->
        EE_REQ.wr && EE_REQ.loc >= 8'h17 && EE_REQ.loc <= 8'h1E)
        else $error("color point save outside 17 to 1E"); // see [R14]
    a_config_mask: assert property (EE_REQ.req && EE_REQ.wr && EE_REQ.loc == 8'h02 |->
        (EE_REQ.wdata & 8'hFD) == 8'h00)
        else $error("configuration byte carries more than polarity"); // see [R13]
    a_nack_keeps: assert property (s_ff.seq == ST_XFER && EE_DONE && !EE_ACK && !REG_WR
        |=> s_ff.mem == $past(s_ff.mem) && s_ff.nack)
        else $error("unacknowledged byte changed registers"); // see [R16]
    a_upl_open_loop: assert property (!s_ff.opmd && !s_ff.save_calib_cmd |=> !s_ff.save_calib_cmd)
        else $error("calibration upload accepted outside open loop"); // see [R15]
    a_upl_clears: assert property (s_ff.seq == ST_FINISH && s_ff.upl_from_bit && !REG_WR
        |=> !s_ff.save_calib_cmd ##1 s_ff.seq == ST_IDLE)
        else $error("calibration upload bit not cleared"); // see [R15]
    a_rsv_zero: assert property (REG_WR && REG_ADDR == 8'h1A |=>
        s_ff.mem[`CSR_LOC_BRT_HI][7:4] == 4'h0)
        else $error("reserved brightness bits stored"); // see [R10]
    a_full_last: assert property (s_ff.seq == ST_XFER && EE_DONE && s_ff.loc == 7'h47
        |=> s_ff.seq == ST_FINISH ##1 !EE_REQ.req)
        else $error("full transfer ran past 47"); // see [R11]

endmodule

// ===== tb/csr_ee_model.sv
/*
 * Byte-wide EEPROM model for the transfer port of the setpoint registers.
 * Assumes requests are held until done and everything runs on one clock.
 */
`timescale 1ns/1ps

module csr_ee_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Transfer port
    input wire csr_pkg::csr_ee_req_s ee_req,
    output logic done,
    output logic ack,
    output logic [7:0] rdata,
    // Test controls and counters
    input wire logic [3:0] lat,
    input wire logic [7:0] nack_loc,
    output logic [15:0] xfer_cnt,
    output logic [15:0] bad_order
);
    import csr_pkg::*;

    // ======================================================================
    // Storage
    logic [7:0] mem [0:127];
    logic [3:0] wait_cnt;
    logic [7:0] prev_loc;

    // Known pattern so untouched locations can be told apart
    initial
    begin
        for (int i = 0; i < 128; i++)
            mem[i] = 8'hA5 ^ i[7:0];
    end

    // One byte per request after lat idle cycles; lines toggle when invalid
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done <= 1'b0;
            ack <= 1'b0;
            rdata <= 8'h00;
            wait_cnt <= 4'h0;
            prev_loc <= 8'h00;
            xfer_cnt <= 16'h0000;
            bad_order <= 16'h0000;
        end
        else if (done || !ee_req.req)
        begin
            done <= 1'b0;
            ack <= ~ack;
            rdata <= ~rdata;
            wait_cnt <= 4'h0;
            if (!ee_req.req)
                prev_loc <= 8'h00;
        end
        else if (wait_cnt < lat)
        begin
            wait_cnt <= wait_cnt + 4'h1;
            ack <= ~ack;
            rdata <= ~rdata;
        end
        else
        begin
            done <= 1'b1;
            ack <= (ee_req.loc != nack_loc);
            rdata <= mem[ee_req.loc[6:0]];
            if (ee_req.wr && ee_req.loc != nack_loc)
                mem[ee_req.loc[6:0]] <= ee_req.wdata;
            if (ee_req.loc <= prev_loc)
                bad_order <= bad_order + 16'h0001;
            prev_loc <= ee_req.loc;
            xfer_cnt <= xfer_cnt + 16'h0001;
        end
    end
endmodule

// ===== tb/csr_top_test.sv
/*
 * Self-checking bench for the setpoint register block and its transfers.
 * Assumes the design files and the EEPROM model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end

module csr_top_test;
    import csr_pkg::*;

    // ======================================================================
    // Signals
    logic clk = 1'b0;
    logic rst_n, reg_wr, ee_done, ee_ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ee_rdata, nack_loc;
    logic [4:0] cmd_v;
    logic [11:0] duty_req, duty_out;
    logic [3:0] lat;
    logic [15:0] xfer_cnt, bad_order, cnt0;
    csr_ee_req_s ee_req;
    int error_cnt = 0;
    int check_count = 0;
    logic [7:0] cp_addr [8] = '{8'h19, 8'h1A, 8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED};
    logic [7:0] cp_val [8] = '{8'h3D, 8'h07, 8'h49, 8'h01, 8'h39, 8'h01, 8'hE8, 8'h03};

    // ======================================================================
    // Design and far side
    csr_top dut (.REF_CLK(clk), .RESETN(rst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .SAVE_ALL_CMD(cmd_v[0]),
        .RESTORE_ALL_CMD(cmd_v[1]), .SAVE_CALIB_CMD(cmd_v[2]),
        .RESTORE_CALIB_CMD(cmd_v[3]), .SAVE_COLOR_POINT_CMD(cmd_v[4]), .EE_REQ(ee_req),
        .EE_DONE(ee_done), .EE_ACK(ee_ack), .EE_RDATA(ee_rdata), .DUTY_REQ(duty_req),
        .DUTY_OUT(duty_out));
    csr_ee_model ee (.clk(clk), .rst_n(rst_n), .ee_req(ee_req), .done(ee_done),
        .ack(ee_ack), .rdata(ee_rdata), .lat(lat), .nack_loc(nack_loc),
        .xfer_cnt(xfer_cnt), .bad_order(bad_order));

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // ======================================================================
    // Tasks
    task summarize;
        $display("errors=%0d checks=%0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Acquisition constant as software works it out, rates retuned when negative
    function automatic logic [7:0] acq_const(input int samp, input int pwm);
        int v;
        if (samp < 2048 * (pwm + 1))
            samp = 2048 * (pwm + 1);
        v = (samp - 512 * (pwm + 1)) / (1536 * (pwm + 1)) - 1;
        if (v > 9)
            v = 9;
        return v[7:0];
    endfunction

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        @(negedge clk);
        `CHK(reg_rdata, e)
    endtask

    task dchk(input logic [11:0] d, input logic [11:0] e);
        @(posedge clk);
        duty_req <= d;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHK(duty_out, e)
    endtask

    task wait_idle;
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        while (ee_req.req === 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 3000)
        begin
            error_cnt++;
            summarize;
        end
        repeat (2) @(posedge clk);
    endtask

    // Start pulse, optionally a second start while busy
    task run(input int i, input bit extra);
        cnt0 = xfer_cnt;
        @(posedge clk);
        cmd_v <= 5'h01 << i;
        @(posedge clk);
        cmd_v <= 5'h00;
        if (extra)
        begin
            repeat (4) @(posedge clk);
            cmd_v <= 5'h02;
            @(posedge clk);
            cmd_v <= 5'h00;
        end
        wait_idle;
    endtask

    // ======================================================================
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        cmd_v = 5'h00;
        duty_req = 12'h000;
        lat = 4'h3;
        nack_loc = 8'hFF;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // Reset values and unmapped read
        rc(8'h19, 8'h79);
        rc(8'h1A, 8'h0E);
        for (int a = 'hE8; a <= 'hED; a++)
            rc(a[7:0], 8'h00);
        rc(8'h30, 8'h00);
        rc(8'h05, 8'h00);
        rc(8'h06, 8'h30);
        rc(8'h07, 8'h75);
        dchk(12'hFFF, 12'hE78);
        // Reserved high bits and setpoints, limit never above its maximum
        wr(8'h1A, 8'hFE);
        rc(8'h1A, 8'h0E);
        for (int i = 2; i < 8; i += 2)
        begin
            wr(cp_addr[i + 1], 8'hFF);
            rc(cp_addr[i + 1], 8'h03);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(cp_addr[i], cp_val[i]);
            rc(cp_addr[i], cp_val[i]);
        end
        wr(8'hA9, acq_const(32'h7530, 0));
        rc(8'hA9, 8'h09);
        dchk(12'hE79, 12'h73C);
        dchk(12'h800, 12'h400);
        // Color point save, restore start while busy is dropped
        run(4, 1'b1);
        `CHK(xfer_cnt - cnt0, 16'd8)
        for (int i = 0; i < 8; i++)
            `CHK(ee.mem[8'h17 + i], cp_val[i])
        `CHK(ee.mem[8'h16], 8'hB3)
        // Full restore, fast memory, one offset byte not acknowledged
        lat <= 4'h1;
        nack_loc <= 8'h23;
        run(1, 1'b0);
        `CHK(xfer_cnt - cnt0, 16'd71)
        rc(8'h81, 8'h00);
        rc(8'hE8, 8'h49);
        rc(8'hEA, 8'h39);
        rc(8'hEB, 8'h01);
        rc(8'h1A, 8'h07);
        rc(8'h03, 8'h02);
        rc(8'h23, 8'h20);
        // Calibration restore
        nack_loc <= 8'hFF;
        wr(8'hEA, 8'h22);
        run(3, 1'b0);
        `CHK(xfer_cnt - cnt0, 16'd51)
        rc(8'hEA, 8'h22);
        rc(8'h81, 8'h86);
        rc(8'h23, 8'h00);
        // Full save, configuration holds more than polarity
        wr(8'h03, 8'hFF);
        rc(8'h03, 8'h07);
        wr(8'h81, 8'h5C);
        run(0, 1'b0);
        `CHK(xfer_cnt - cnt0, 16'd71)
        `CHK(ee.mem[8'h02], 8'h02)
        `CHK(ee.mem[8'h23], 8'h5C)
        `CHK(ee.mem[8'h48], 8'hED)
        // Calibration save by command and from the upload bit, open loop only
        run(2, 1'b0);
        `CHK(xfer_cnt - cnt0, 16'd51)
        wr(8'h02, 8'h10);
        rc(8'h02, 8'h00);
        wr(8'h04, 8'h01);
        cnt0 = xfer_cnt;
        wr(8'h02, 8'h10);
        rc(8'h02, 8'h10);
        wait_idle;
        `CHK(xfer_cnt - cnt0, 16'd51)
        rc(8'h02, 8'h00);
        `CHK(bad_order, 16'd0)
        summarize;
    end
endmodule
